// File: brfc_core.sv
// Contract
// - normal mode: output shows reads only
// - write-through: write data echoed on output
// - read-before-write: old contents shown while writing
// - fifo write and read sides, own clocks
// - full, almost-full registered on write clock
// - empty, almost-empty registered on read clock
// - programmable thresholds, empty fixed at zero
// - global clear resets pointers and flags
// - read pointer clear replays stored data
// - port output latches, sync or async clear
// - port clears act on own port only
// - device-wide reset clears both port latches
module brfc_core (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire brfc_pkg::brfc_port_req_s port_a_i,
  input wire brfc_pkg::brfc_port_req_s port_b_i,
  input wire logic port_a_output_clear_i,
  input wire logic port_b_output_clear_i,
  output logic [brfc_pkg::DATA_W-1:0] port_a_rdata_o,
  output logic [brfc_pkg::DATA_W-1:0] port_b_rdata_o,
  input wire brfc_pkg::brfc_fifo_pins_s fifo_pins_i,
  output logic [brfc_pkg::DATA_W-1:0] fifo_rdata_o,
  output logic fifo_full_o,
  output logic fifo_almost_full_o,
  output logic fifo_almost_empty_o,
  output logic fifo_empty_o,
  output logic irq_o,
  input wire logic [brfc_pkg::REG_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [brfc_pkg::REG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int PW = $bits(brfc_pkg::brfc_fifo_pins_s);
  localparam int AW = brfc_pkg::ADDR_W;
  localparam int DW = brfc_pkg::DATA_W;

  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == brfc_pkg::OFS_CTRL) || (a == brfc_pkg::OFS_THR_FULL)
      || (a == brfc_pkg::OFS_THR_AFULL) || (a == brfc_pkg::OFS_THR_AEMPTY)
      || (a == brfc_pkg::OFS_STATUS) || (a == brfc_pkg::OFS_IRQ_STAT)
      || (a == brfc_pkg::OFS_IRQ_MASK);
  endfunction

  // value a port latch takes for an enabled access
  function automatic logic [DW-1:0] port_next(
    input brfc_pkg::brfc_wmode_e m, input logic we,
    input logic [DW-1:0] wd, input logic [DW-1:0] old);
    port_next = old;
    if (we && m == brfc_pkg::BRFC_WM_THROUGH) begin
      port_next = wd;
    end
  endfunction

  logic [DW-1:0] mem [brfc_pkg::DEPTH];
  logic [brfc_pkg::CTRL_W-1:0] ctrl;
  logic [AW-1:0] thr_full;
  logic [AW-1:0] thr_afull;
  logic [AW-1:0] thr_aempty;
  logic [brfc_pkg::IRQ_W-1:0] irq_stat;
  logic [brfc_pkg::IRQ_W-1:0] irq_mask;
  logic [PW-1:0] sync1;
  logic [PW-1:0] sync2;
  logic wclk_prev;
  logic rclk_prev;
  logic [brfc_pkg::PTR_W-1:0] wptr;
  logic [brfc_pkg::PTR_W-1:0] rptr;
  logic [brfc_pkg::FLAG_W-1:0] flags;
  logic [DW-1:0] fifo_rdata;

  brfc_pkg::brfc_fifo_pins_s pins;
  brfc_pkg::brfc_wmode_e wmode;
  logic fifo_en;
  logic latch_async;
  assign pins = brfc_pkg::brfc_fifo_pins_s'(sync2);
  assign wmode = brfc_pkg::brfc_wmode_e'(ctrl[brfc_pkg::CTRL_MODE_LSB +: 2]);
  assign fifo_en = ctrl[brfc_pkg::CTRL_FIFO_BIT];
  assign latch_async = ctrl[brfc_pkg::CTRL_ASYNC_BIT];

  // pins from the fabric clocks pass two flops first
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
      wclk_prev <= 1'b0;
      rclk_prev <= 1'b0;
    end else begin
      sync1 <= PW'(fifo_pins_i);
      sync2 <= sync1;
      wclk_prev <= pins.write_side_clock;
      rclk_prev <= pins.read_side_clock;
    end
  end

  // edges of the two side clocks
  wire wr_edge = pins.write_side_clock & ~wclk_prev;
  wire rd_edge = pins.read_side_clock & ~rclk_prev;
  wire gclr = pins.global_clear;
  wire wr_try = wr_edge & fifo_en & pins.write_clock_enable & pins.write_strobe;
  wire rd_try = rd_edge & fifo_en & pins.read_clock_enable & pins.read_strobe;
  wire wr_fire = wr_try & ~flags[brfc_pkg::FL_FULL] & ~gclr;
  wire rd_fire = rd_try & ~flags[brfc_pkg::FL_EMPTY] & ~gclr;

  wire [brfc_pkg::PTR_W-1:0] next_wptr = gclr ? '0 :
    brfc_pkg::PTR_W'(wptr + brfc_pkg::PTR_W'(wr_fire));
  // read pointer clear leaves write pointer alone
  wire [brfc_pkg::PTR_W-1:0] next_rptr = (gclr | pins.read_pointer_clear) ?
    '0 : brfc_pkg::PTR_W'(rptr + brfc_pkg::PTR_W'(rd_fire));
  wire [brfc_pkg::PTR_W-1:0] next_cnt =
    brfc_pkg::PTR_W'(next_wptr - next_rptr);
  wire [brfc_pkg::PTR_W-1:0] cnt = brfc_pkg::PTR_W'(wptr - rptr);

  // threshold compares, empty level fixed at zero
  wire cmp_full = next_cnt >= {1'b0, thr_full};
  wire cmp_afull = next_cnt >= {1'b0, thr_afull};
  wire cmp_aempty = next_cnt <= {1'b0, thr_aempty};
  wire cmp_empty = next_cnt == {1'b0, brfc_pkg::THR_EMPTY};

  logic [brfc_pkg::FLAG_W-1:0] next_flags;
  always_comb begin
    next_flags = flags;
    if (gclr) begin
      next_flags = brfc_pkg::FLAGS_RST;
    end else begin
      // full pair on write clock edges
      if (wr_edge) begin
        next_flags[brfc_pkg::FL_FULL] = cmp_full;
        next_flags[brfc_pkg::FL_AFULL] = cmp_afull;
      end
      // empty pair on read clock edges
      if (rd_edge) begin
        next_flags[brfc_pkg::FL_EMPTY] = cmp_empty;
        next_flags[brfc_pkg::FL_AEMPTY] = cmp_aempty;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr <= '0;
      rptr <= '0;
      flags <= brfc_pkg::FLAGS_RST;
      fifo_rdata <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      flags <= next_flags;
      if (rd_fire) begin
        fifo_rdata <= mem[rptr[AW-1:0]];
      end
    end
  end

  assign fifo_rdata_o = fifo_rdata;
  assign fifo_empty_o = flags[brfc_pkg::FL_EMPTY];
  assign fifo_almost_empty_o = flags[brfc_pkg::FL_AEMPTY];
  assign fifo_almost_full_o = flags[brfc_pkg::FL_AFULL];
  assign fifo_full_o = flags[brfc_pkg::FL_FULL];

  // ram ports write only outside fifo use; port a wins a collision
  wire a_wr = port_a_i.en & port_a_i.we & ~fifo_en;
  wire b_wr = port_b_i.en & port_b_i.we & ~fifo_en;
  always_ff @(posedge clk_sys_i) begin
    if (wr_fire) begin
      mem[wptr[AW-1:0]] <= pins.wdata;
    end
    if (b_wr && !(a_wr && port_a_i.addr == port_b_i.addr)) begin
      mem[port_b_i.addr] <= port_b_i.wdata;
    end
    if (a_wr) begin
      mem[port_a_i.addr] <= port_a_i.wdata;
    end
  end

  // normal mode holds the latch during writes
  wire a_load = port_a_i.en &
    ~(port_a_i.we & wmode == brfc_pkg::BRFC_WM_NORMAL);
  wire b_load = port_b_i.en &
    ~(port_b_i.we & wmode == brfc_pkg::BRFC_WM_NORMAL);
  // through echoes input, rbw shows old word
  wire [DW-1:0] a_din = port_next(wmode, port_a_i.we, port_a_i.wdata,
    mem[port_a_i.addr]);
  wire [DW-1:0] b_din = port_next(wmode, port_b_i.we, port_b_i.wdata,
    mem[port_b_i.addr]);
  wire a_clr = port_a_output_clear_i | ~pins.device_wide_reset_n;
  wire b_clr = port_b_output_clear_i | ~pins.device_wide_reset_n;

  // output latches with selectable clear style
  brfc_out_latch u_latch_a (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .load_i(a_load),
    .din_i(a_din),
    .clr_i(a_clr),
    .async_i(latch_async),
    .dout_o(port_a_rdata_o)
  );
  brfc_out_latch u_latch_b (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .load_i(b_load),
    .din_i(b_din),
    .clr_i(b_clr),
    .async_i(latch_async),
    .dout_o(port_b_rdata_o)
  );

  // axi4-lite write channel
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  wire wr_go = aw_held & w_held;
  wire wr_ok = reg_known(aw_addr);
  wire wr_commit = wr_go & wr_ok & w_lane0;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= brfc_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? brfc_pkg::RESP_OKAY : brfc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  wire ar_take = s_axi_arvalid & s_axi_arready;
  assign s_axi_arready = ~s_axi_rvalid;
  wire ar_ok = reg_known(s_axi_araddr);
  wire irq_rd_clr = ar_take & (s_axi_araddr == brfc_pkg::OFS_IRQ_STAT);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (s_axi_araddr)
      brfc_pkg::OFS_CTRL: rd_mux[brfc_pkg::CTRL_W-1:0] = ctrl;
      brfc_pkg::OFS_THR_FULL: rd_mux[AW-1:0] = thr_full;
      brfc_pkg::OFS_THR_AFULL: rd_mux[AW-1:0] = thr_afull;
      brfc_pkg::OFS_THR_AEMPTY: rd_mux[AW-1:0] = thr_aempty;
      brfc_pkg::OFS_STATUS: begin
        rd_mux[brfc_pkg::FLAG_W-1:0] = flags;
        rd_mux[brfc_pkg::STAT_CNT_LSB +: brfc_pkg::PTR_W] = cnt;
      end
      brfc_pkg::OFS_IRQ_STAT: rd_mux[brfc_pkg::IRQ_W-1:0] = irq_stat;
      brfc_pkg::OFS_IRQ_MASK: rd_mux[brfc_pkg::IRQ_W-1:0] = irq_mask;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= brfc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= ar_ok ? brfc_pkg::RESP_OKAY : brfc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // register writes, low byte lane only
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= brfc_pkg::CTRL_RST;
      thr_full <= brfc_pkg::THR_FULL_RST;
      thr_afull <= brfc_pkg::THR_AFULL_RST;
      thr_aempty <= brfc_pkg::THR_AEMPTY_RST;
      irq_mask <= brfc_pkg::IRQ_MASK_RST;
    end else if (wr_commit) begin
      unique case (aw_addr)
        brfc_pkg::OFS_CTRL: ctrl <= w_data[brfc_pkg::CTRL_W-1:0];
        brfc_pkg::OFS_THR_FULL: thr_full <= w_data[AW-1:0];
        brfc_pkg::OFS_THR_AFULL: thr_afull <= w_data[AW-1:0];
        brfc_pkg::OFS_THR_AEMPTY: thr_aempty <= w_data[AW-1:0];
        brfc_pkg::OFS_IRQ_MASK: irq_mask <= w_data[brfc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky events; a new event beats the read clear
  wire [brfc_pkg::FLAG_W-1:0] flag_rise = next_flags & ~flags;
  wire [brfc_pkg::IRQ_W-1:0] irq_ev = {rd_try & flags[brfc_pkg::FL_EMPTY],
    wr_try & flags[brfc_pkg::FL_FULL], flag_rise};
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_rd_clr ? '0 : irq_stat) | irq_ev;
    end
  end
  assign irq_o = |(irq_stat & irq_mask);
endmodule

// File: brfc_core_props.sv
module brfc_core_chk (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire brfc_pkg::brfc_fifo_pins_s fifo_pins_i,
  input wire logic port_a_output_clear_i,
  input wire logic port_b_output_clear_i,
  input wire logic [brfc_pkg::DATA_W-1:0] port_a_rdata_o,
  input wire logic [brfc_pkg::DATA_W-1:0] port_b_rdata_o,
  input wire logic fifo_full_o,
  input wire logic fifo_almost_full_o,
  input wire logic fifo_almost_empty_o,
  input wire logic fifo_empty_o,
  input wire logic irq_o,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  // recent samples of side clocks and global clear
  logic [4:0] wh, rh, gh;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wh <= '0;
      rh <= '0;
      gh <= '0;
    end else begin
      wh <= {wh[3:0], fifo_pins_i.write_side_clock};
      rh <= {rh[3:0], fifo_pins_i.read_side_clock};
      gh <= {gh[3:0], fifo_pins_i.global_clear};
    end
  end
  a_full_wclk: assert property (
    $changed({fifo_full_o, fifo_almost_full_o}) |-> (|wh) || (|gh))
    else $error("full flags moved without write clock");
  a_empty_rclk: assert property (
    $changed({fifo_empty_o, fifo_almost_empty_o}) |-> (|rh) || (|gh))
    else $error("empty flags moved without read clock");
  a_empty_aempty: assert property (
    fifo_empty_o |-> fifo_almost_empty_o)
    else $error("empty without almost empty");
  a_full_afull: assert property (
    fifo_full_o |-> fifo_almost_full_o)
    else $error("full without almost full");
  a_gclr_flags: assert property (
    fifo_pins_i.global_clear [*5] |-> fifo_empty_o && fifo_almost_empty_o
      && !fifo_full_o && !fifo_almost_full_o)
    else $error("global clear left flags set");
  a_clear_a: assert property (
    port_a_output_clear_i |=> port_a_rdata_o == '0)
    else $error("port a latch not cleared");
  a_clear_b: assert property (
    port_b_output_clear_i |=> port_b_rdata_o == '0)
    else $error("port b latch not cleared");
  a_gsr_both: assert property (
    !fifo_pins_i.device_wide_reset_n [*4] |->
      port_a_rdata_o == '0 && port_b_rdata_o == '0)
    else $error("device reset left a latch set");
  a_ar_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  c_full_irq: cover property (fifo_full_o && irq_o);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_clear_b: cover property (port_b_output_clear_i ##1 port_b_rdata_o == '0);
endmodule

bind brfc_core brfc_core_chk chk (
  .clk_sys_i, .arst_n_i, .fifo_pins_i, .port_a_output_clear_i,
  .port_b_output_clear_i, .port_a_rdata_o, .port_b_rdata_o, .fifo_full_o,
  .fifo_almost_full_o, .fifo_almost_empty_o, .fifo_empty_o, .irq_o,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp
);

// File: brfc_core_test.sv
module brfc_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, arst_n_i, port_a_output_clear_i, port_b_output_clear_i;
  brfc_pkg::brfc_port_req_s port_a_i, port_b_i;
  brfc_pkg::brfc_fifo_pins_s fifo_pins_i;
  logic [8:0] port_a_rdata_o, port_b_rdata_o, fifo_rdata_o, y, d0, d1;
  logic [8:0] f [4];
  logic fifo_full_o, fifo_almost_full_o, fifo_almost_empty_o, fifo_empty_o;
  logic irq_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] rq [$], mq [$];
  logic [1:0] bq [$];
  logic [31:0] rv [7] = '{32'h0, 32'hF, 32'hC, 32'h3, 32'h3, 32'h0, 32'h0};
  int failures = 0, n_checks = 0, cyc = 0;
  brfc_core dut (.clk_sys_i, .arst_n_i, .port_a_i, .port_b_i,
    .port_a_output_clear_i, .port_b_output_clear_i, .port_a_rdata_o,
    .port_b_rdata_o, .fifo_pins_i, .fifo_rdata_o, .fifo_full_o,
    .fifo_almost_full_o, .fifo_almost_empty_o, .fifo_empty_o, .irq_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  brfc_fab fab (.clk_sys_i, .pins_o(fifo_pins_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [8:0] nxt();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[8:0];
  endfunction
  function automatic logic [1:0] resp(input logic [7:0] a);
    return a > brfc_pkg::OFS_IRQ_MASK ? brfc_pkg::RESP_SLVERR :
      brfc_pkg::RESP_OKAY;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clk_sys_i);
    bq.push_back(resp(a));
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge clk_sys_i);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      @(posedge clk_sys_i);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    logic ha, hr;
    @(posedge clk_sys_i);
    rq.push_back({resp(a), e & m});
    mq.push_back({2'h3, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge clk_sys_i);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid && s_axi_rready;
      @(posedge clk_sys_i);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic port(input bit b, input logic we, input logic [3:0] a,
      input logic [8:0] d);
    @(posedge clk_sys_i);
    if (b) port_b_i <= '{1'b1, we, a, d};
    else port_a_i <= '{1'b1, we, a, d};
    @(posedge clk_sys_i);
    port_a_i.en <= 1'b0;
    port_b_i.en <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  always @(negedge clk_sys_i) begin
    if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      check({s_axi_rresp, s_axi_rdata} & mq.pop_front(), rq.pop_front());
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    {port_a_i, port_b_i, port_a_output_clear_i, port_b_output_clear_i} = '0;
    s_axi_wstrb = 4'hF;
    arst_n_i = 1'b0;
    seed = 32'hFC9A;
    repeat (16) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    fab.step(4);
    for (int i = 0; i < 8; i++) rd(8'(i * 4), rv[i % 7], i == 5 ? '0 : '1);
    wr(8'h40, 32'h1);
    y = nxt();
    port(1, 1, 4'h6, y);
    for (int m = 0; m < 3; m++) begin
      wr(brfc_pkg::OFS_CTRL, 32'(m));
      d0 = nxt();
      d1 = nxt();
      port(0, 1, 4'h5, d0);
      port(0, 0, 4'h6, 9'h0);
      check(port_a_rdata_o, y);
      port(0, 1, 4'h5, d1);
      check(port_a_rdata_o, m == 0 ? y : m == 1 ? d1 : d0);
    end
    port(1, 0, 4'h5, 9'h0);
    check(port_b_rdata_o, d1);
    wr(brfc_pkg::OFS_CTRL, 32'h0);
    @(posedge clk_sys_i) port_a_output_clear_i <= 1'b1;
    @(negedge clk_sys_i) check(port_a_rdata_o, d0);
    @(posedge clk_sys_i) port_a_output_clear_i <= 1'b0;
    @(negedge clk_sys_i) check(port_a_rdata_o, 0);
    check(port_b_rdata_o, d1);
    wr(brfc_pkg::OFS_CTRL, 32'h8);
    port(0, 0, 4'h5, 9'h0);
    @(posedge clk_sys_i) port_b_output_clear_i <= 1'b1;
    #5 check(port_b_rdata_o, 0);
    check(port_a_rdata_o, d1);
    @(posedge clk_sys_i) port_b_output_clear_i <= 1'b0;
    port(1, 0, 4'h6, 9'h0);
    fab.lvl(0, 0, 0);
    check({port_a_rdata_o, port_b_rdata_o}, 0);
    fab.lvl(0, 0, 1);
    wr(brfc_pkg::OFS_CTRL, 32'h4);
    wr(brfc_pkg::OFS_THR_FULL, 32'h4);
    wr(brfc_pkg::OFS_THR_AFULL, 32'h2);
    wr(brfc_pkg::OFS_THR_AEMPTY, 32'h1);
    wr(brfc_pkg::OFS_IRQ_MASK, 32'h8);
    rd(brfc_pkg::OFS_IRQ_STAT, 0, 0);
    for (int i = 0; i < 5; i++) begin
      if (i < 4) f[i] = nxt();
      fab.side(0, i < 4 ? f[i] : 9'h1FF);
    end
    check({fifo_full_o, irq_o}, 2'h3);
    rd(brfc_pkg::OFS_STATUS, 32'h4F, 32'h1FF);
    rd(brfc_pkg::OFS_IRQ_STAT, 32'h1C, 32'h3F);
    @(negedge clk_sys_i) check(irq_o, 0);
    // empty is stale until a read-side edge, so this first read is refused
    fab.side(1, 9'h0);
    check(fifo_rdata_o, 0);
    rd(brfc_pkg::OFS_IRQ_STAT, 32'h20, 32'h20);
    for (int i = 0; i < 2; i++) begin
      fab.side(1, 9'h0);
      check(fifo_rdata_o, f[i]);
    end
    check({fifo_almost_empty_o, fifo_empty_o}, 0);
    fab.lvl(0, 1, 1);
    fab.lvl(0, 0, 1);
    fab.side(1, 9'h0);
    check(fifo_rdata_o, f[0]);
    rd(brfc_pkg::OFS_STATUS, 32'h3C, 32'h1FF);
    fab.lvl(1, 0, 1);
    fab.lvl(0, 0, 1);
    check({fifo_full_o, fifo_almost_full_o, fifo_almost_empty_o,
      fifo_empty_o}, 4'h3);
    rd(brfc_pkg::OFS_STATUS, 32'h3, 32'h1FF);
    fab.side(1, 9'h0);
    rd(brfc_pkg::OFS_IRQ_STAT, 32'h20, 32'h20);
    end_of_test();
  end
endmodule

// File: brfc_fab.sv
module brfc_fab (
  input wire logic clk_sys_i,
  output brfc_pkg::brfc_fifo_pins_s pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pins_o = '0;
    pins_o.device_wide_reset_n = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic side(input bit rd, input logic [8:0] d);
    @(posedge clk_sys_i);
    if (rd) begin
      pins_o.read_clock_enable <= 1'b1;
      pins_o.read_strobe <= 1'b1;
    end else begin
      pins_o.write_clock_enable <= 1'b1;
      pins_o.write_strobe <= 1'b1;
      pins_o.wdata <= d;
    end
    step(4);
    pins_o.read_side_clock <= rd;
    pins_o.write_side_clock <= !rd;
    step(4);
    pins_o.read_side_clock <= 1'b0;
    pins_o.write_side_clock <= 1'b0;
    step(4);
    pins_o.read_clock_enable <= 1'b0;
    pins_o.read_strobe <= 1'b0;
    pins_o.write_clock_enable <= 1'b0;
    pins_o.write_strobe <= 1'b0;
    pins_o.wdata <= ~pins_o.wdata;
  endtask
  // replay asked only while data intact
  task automatic lvl(input logic gc, input logic rp, input logic gsr_n);
    @(posedge clk_sys_i);
    pins_o.global_clear <= gc;
    pins_o.read_pointer_clear <= rp;
    pins_o.device_wide_reset_n <= gsr_n;
    step(6);
  endtask
endmodule

// File: brfc_out_latch.sv
module brfc_out_latch (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic [brfc_pkg::DATA_W-1:0] din_i,
  input wire logic clr_i,
  input wire logic async_i,
  output logic [brfc_pkg::DATA_W-1:0] dout_o
);
  logic rst_n_int;

  // async mode folds the clear into the flop reset
  assign rst_n_int = arst_n_i & ~(clr_i & async_i);

  always_ff @(posedge clk_sys_i or negedge rst_n_int) begin
    if (!rst_n_int) begin
      dout_o <= '0;
    end else if (clr_i) begin
      dout_o <= '0;
    end else if (load_i) begin
      dout_o <= din_i;
    end
  end
endmodule

// File: brfc_pkg.sv
package brfc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 9;
  localparam int DEPTH = 16;
  localparam int PTR_W = 5;
  localparam int REG_AW = 8;
  localparam int FLAG_W = 4;
  localparam int IRQ_W = 6;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THR_FULL = 8'h04;
  localparam logic [7:0] OFS_THR_AFULL = 8'h08;
  localparam logic [7:0] OFS_THR_AEMPTY = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FIFO_BIT = 2;
  localparam int CTRL_ASYNC_BIT = 3;
  localparam int CTRL_W = 4;

  // flag bit positions, shared by status and interrupt layout
  localparam int FL_EMPTY = 0;
  localparam int FL_AEMPTY = 1;
  localparam int FL_AFULL = 2;
  localparam int FL_FULL = 3;
  localparam int EV_WR_REFUSED = 4;
  localparam int EV_RD_REFUSED = 5;
  localparam int STAT_CNT_LSB = 4;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [ADDR_W-1:0] THR_FULL_RST = 4'hF;
  localparam logic [ADDR_W-1:0] THR_AFULL_RST = 4'hC;
  localparam logic [ADDR_W-1:0] THR_AEMPTY_RST = 4'h3;
  localparam logic [ADDR_W-1:0] THR_EMPTY = 4'h0;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pin synchroniser depth before logic sees a value
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    BRFC_WM_NORMAL,
    BRFC_WM_THROUGH,
    BRFC_WM_RBW
  } brfc_wmode_e;

  typedef struct packed {
    logic en;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } brfc_port_req_s;

  typedef struct packed {
    logic write_side_clock;
    logic write_clock_enable;
    logic write_strobe;
    logic [DATA_W-1:0] wdata;
    logic read_side_clock;
    logic read_clock_enable;
    logic read_strobe;
    logic global_clear;
    logic read_pointer_clear;
    logic device_wide_reset_n;
  } brfc_fifo_pins_s;
endpackage
